// File: common/dram_ctrl_params.svh
// timing counts and field positions for the dynamic memory controller
// assumes a 20 MHz system clock; all figures are converted to cycles here
`ifndef DRAM_CTRL_PARAMS_SVH
`define DRAM_CTRL_PARAMS_SVH

`define CLK_PERIOD_NS 50
// strobe phase length in cycles (every strobe level is held at least this long)
`define PHASE_CYC 2
// power-up pause
`define PWR_PAUSE_US 200
`define PWR_PAUSE_CYC ((`PWR_PAUSE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYCLES 8
// distributed refresh spacing
`define REF_ROWS 512
`define REF_PERIOD_NS 15600
`define REF_CYC (`REF_PERIOD_NS / `CLK_PERIOD_NS)
// longest gap without a row strobe cycle before re-initialisation
`define IDLE_LIMIT_MS 8
`define IDLE_LIMIT_CYC (`IDLE_LIMIT_MS * 1000000 / `CLK_PERIOD_NS)
// address split
`define ROW_LSB 10
`define ROW_W 10
`define COL_W 10
`define REF_ROW_W 9
`define CNT_W 13
`define IDLE_W 18

`endif

// File: common/dram_ctrl_pkg.sv
// types shared by the dynamic memory controller
// assumes dram_ctrl_params.svh is on the include path
package dram_ctrl_pkg;
	`include "dram_ctrl_params.svh"

	typedef enum logic [10:0] {
		ST_PWR = 11'h001,
		ST_IDLE = 11'h002,
		ST_ROW = 11'h004,
		ST_COL = 11'h008,
		ST_PAGE = 11'h010,
		ST_HID_UP = 11'h020,
		ST_HID_DN = 11'h040,
		ST_CBR = 11'h080,
		ST_CBR_RAS = 11'h100,
		ST_TEST_UP = 11'h200,
		ST_PRE = 11'h400
	} st_t;

	typedef enum logic [1:0] {
		KIND_REF_RO = 2'h0,
		KIND_REF_CBR = 2'h1,
		KIND_ACCESS = 2'h2,
		KIND_TEST = 2'h3
	} kind_t;

	typedef enum logic {
		OP_READ = 1'b0,
		OP_WRITE = 1'b1
	} op_t;

	// one user request
	typedef struct packed {
		logic test;
		logic hidden;
		logic keep;
		op_t op;
		logic [19:0] addr;
		logic wdata;
	} req_t;

	// memory pins driven by the controller
	typedef struct packed {
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [9:0] addr;
		logic din;
	} pins_t;

	typedef struct packed {
		st_t st;
		kind_t kind;
		logic [`CNT_W-1:0] cnt;
		logic [8:0] ref_tmr;
		logic ref_pend;
		logic [`IDLE_W-1:0] idle_tmr;
		logic [3:0] init_left;
		logic init_busy;
		logic [`REF_ROW_W-1:0] ref_row;
		logic [`ROW_W-1:0] open_row;
		req_t req;
		logic have;
		pins_t pins;
		logic ready;
		logic rd_valid;
		logic rd_data;
	} state_t;
endpackage

// File: rtl/dram_ctrl.sv
// controller for an asynchronous 1M x 1 dynamic memory with fast page mode
// assumes the memory pins are registered outputs and the data output is sampled on I_CLK
//
// How it works
// - Row-only strobe with column strobe high refreshes the addressed row.
// - Row-only refresh walks all 512 rows in turn.
// - Column strobe falls a setup time before row strobe for internal refresh.
// - Column strobe held low after read while row strobe cycles: hidden refresh.
// - Counter test: internal refresh, column strobe up and down, then access.
// - Page mode keeps row strobe low and cycles column strobe per column.
// - Wait 200 us after power-up, then eight initialisation cycles.
// - After 8 ms without row strobe cycles, eight initialisation cycles again.
// - Any row strobe cycle counts as an initialisation cycle.
// - Both strobes held high during power-up.
// - Every row refreshed at least once in each 8 ms.
// - Ten row bits latched on row strobe fall, ten column bits on column fall.
`timescale 1ns/1ps

module dram_ctrl
	import dram_ctrl_pkg::*;
#(
	parameter int IDLE_LIMIT = `IDLE_LIMIT_CYC
) (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic i_REQ_VALID,
	input wire req_t i_REQ,
	input wire logic i_RAS_ONLY_REF,
	input wire logic i_DOUT,
	output logic o_REQ_READY,
	output logic o_RD_VALID,
	output logic o_RD_DATA,
	output logic o_INIT_BUSY,
	output logic o_RAS_N,
	output logic o_CAS_N,
	output logic o_WE_N,
	output logic [9:0] o_ADDR,
	output logic o_DIN
);

	// ****************************************
	// helpers
	// ****************************************

	// move to a state and restart the phase counter
	function automatic state_t enter(input state_t x, input st_t st);
		state_t y;
		y = x;
		y.st = st;
		y.cnt = '0;
		return y;
	endfunction

	// column phase: strobe the column of the held request
	function automatic state_t start_col(input state_t x);
		state_t y;
		y = enter(x, ST_COL);
		y.pins.cas_n = 1'b0;
		y.pins.addr = x.req.addr[`COL_W-1:0];
		y.pins.we_n = (x.req.op == OP_READ);
		y.pins.din = x.req.wdata;
		y.have = 1'b0;
		return y;
	endfunction

	// all strobes high for precharge
	function automatic state_t start_pre(input state_t x);
		state_t y;
		y = enter(x, ST_PRE);
		y.pins.ras_n = 1'b1;
		y.pins.cas_n = 1'b1;
		y.pins.we_n = 1'b1;
		return y;
	endfunction

	state_t s;
	state_t next_s;
	logic done;

	assign done = (s.cnt == `CNT_W'(`PHASE_CYC - 1));

	// ****************************************
	// sequencer
	// ****************************************

	// next state of the whole controller
	always_comb begin
		next_s = s;
		next_s.rd_valid = 1'b0;
		next_s.cnt = s.cnt + `CNT_W'(1);
		if (s.idle_tmr != '1) begin
			next_s.idle_tmr = s.idle_tmr + `IDLE_W'(1);
		end
		if (s.ready && i_REQ_VALID) begin
			next_s.req = i_REQ;
			next_s.have = 1'b1;
		end
		case (s.st)
			ST_PWR: begin
				next_s.pins.ras_n = 1'b1;
				next_s.pins.cas_n = 1'b1;
				if (s.cnt == `CNT_W'(`PWR_PAUSE_CYC - 1)) begin
					next_s = enter(next_s, ST_IDLE);
					next_s.init_left = 4'(`INIT_CYCLES);
				end
			end
			ST_IDLE: begin
				if (s.idle_tmr >= `IDLE_W'(IDLE_LIMIT - 1) && s.init_left == 4'h0) begin
					next_s.init_left = 4'(`INIT_CYCLES);
					next_s.init_busy = 1'b1;
				end else if (s.init_left != 4'h0 || (s.ref_pend && i_RAS_ONLY_REF)) begin
					// row-only refresh, also used for initialisation
					next_s = enter(next_s, ST_ROW);
					next_s.kind = KIND_REF_RO;
					next_s.pins.ras_n = 1'b0;
					next_s.pins.addr = {1'b0, s.ref_row};
					next_s.ref_pend = 1'b0;
					next_s.idle_tmr = '0;
				end else if (s.ref_pend) begin
					next_s = enter(next_s, ST_CBR);
					next_s.kind = KIND_REF_CBR;
					next_s.pins.cas_n = 1'b0;
				end else if (s.have && s.req.test) begin
					next_s = enter(next_s, ST_CBR);
					next_s.kind = KIND_TEST;
					next_s.pins.cas_n = 1'b0;
				end else if (s.have) begin
					next_s = enter(next_s, ST_ROW);
					next_s.kind = KIND_ACCESS;
					next_s.pins.ras_n = 1'b0;
					next_s.pins.addr = s.req.addr[`ROW_LSB +: `ROW_W];
					next_s.open_row = s.req.addr[`ROW_LSB +: `ROW_W];
					next_s.idle_tmr = '0;
				end
			end
			ST_ROW: begin
				if (done && s.kind == KIND_REF_RO) begin
					next_s = start_pre(next_s);
					next_s.ref_row = s.ref_row + `REF_ROW_W'(1);
				end else if (done) begin
					next_s = start_col(next_s);
				end
			end
			ST_COL: begin
				if (done) begin
					if (s.req.op == OP_READ) begin
						next_s.rd_data = i_DOUT;
						next_s.rd_valid = 1'b1;
					end
					next_s.pins.we_n = 1'b1;
					if (s.kind == KIND_ACCESS && s.req.hidden && s.req.op == OP_READ) begin
						next_s = enter(next_s, ST_HID_UP);
						next_s.pins.ras_n = 1'b1;
					end else if (s.kind == KIND_ACCESS && s.req.keep) begin
						next_s = enter(next_s, ST_PAGE);
						next_s.pins.cas_n = 1'b1;
					end else begin
						next_s = start_pre(next_s);
					end
				end
			end
			ST_PAGE: begin
				// row stays open; same-row requests of either kind, except counter tests, go straight to a column phase
				if (s.ref_pend) begin
					next_s = start_pre(next_s);
				end else if (s.have && !s.req.test && s.req.addr[`ROW_LSB +: `ROW_W] == s.open_row) begin
					next_s = start_col(next_s);
				end else if (s.have) begin
					next_s = start_pre(next_s);
				end
			end
			ST_HID_UP: begin
				if (done) begin
					next_s = enter(next_s, ST_HID_DN);
					next_s.pins.ras_n = 1'b0;
					next_s.ref_pend = 1'b0;
					next_s.idle_tmr = '0;
				end
			end
			ST_HID_DN: begin
				if (done) begin
					next_s = start_pre(next_s);
				end
			end
			ST_CBR: begin
				if (done) begin
					next_s = enter(next_s, ST_CBR_RAS);
					next_s.pins.ras_n = 1'b0;
					next_s.ref_pend = 1'b0;
					next_s.idle_tmr = '0;
				end
			end
			ST_CBR_RAS: begin
				if (done && s.kind == KIND_TEST) begin
					next_s = enter(next_s, ST_TEST_UP);
					next_s.pins.cas_n = 1'b1;
				end else if (done) begin
					next_s = start_pre(next_s);
				end
			end
			ST_TEST_UP: begin
				if (done) begin
					next_s = start_col(next_s);
				end
			end
			ST_PRE: begin
				if (done) begin
					next_s = enter(next_s, ST_IDLE);
					if (s.init_left != 4'h0) begin
						next_s.init_left = s.init_left - 4'h1;
					end
					if (s.init_left <= 4'h1) begin
						next_s.init_busy = 1'b0;
					end
				end
			end
			default: begin
				next_s = start_pre(next_s);
			end
		endcase
		// refresh timer; its set wins over a clear above
		if (s.ref_tmr == 9'(`REF_CYC - 1)) begin
			next_s.ref_tmr = '0;
			next_s.ref_pend = 1'b1;
		end else begin
			next_s.ref_tmr = s.ref_tmr + 9'h001;
		end
		next_s.ready = (next_s.st == ST_IDLE || next_s.st == ST_PAGE) && !next_s.have &&
			!next_s.init_busy && !next_s.ref_pend && next_s.init_left == 4'h0;
	end

	// state register
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			s <= '0;
			s.st <= ST_PWR;
			s.init_busy <= 1'b1;
			s.pins <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: 10'h000, din: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign o_REQ_READY = s.ready;
	assign o_RD_VALID = s.rd_valid;
	assign o_RD_DATA = s.rd_data;
	assign o_INIT_BUSY = s.init_busy;
	assign o_RAS_N = s.pins.ras_n;
	assign o_CAS_N = s.pins.cas_n;
	assign o_WE_N = s.pins.we_n;
	assign o_ADDR = s.pins.addr;
	assign o_DIN = s.pins.din;

	// ****************************************
	// checks
	// ****************************************

	logic [3:0] init_ras;
	logic [9:0] since_ref;

	// row strobe falls during initialisation, and cycles since the last refresh
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || !s.init_busy) begin
			init_ras <= 4'h0;
		end else if (s.st == ST_ROW && s.cnt == '0) begin
			init_ras <= init_ras + 4'h1;
		end
		// the power-up pause holds no charge worth keeping, so the gap count starts after it
		if (I_SYS_RST || s.st == ST_PWR || (s.st == ST_ROW && s.kind == KIND_REF_RO) ||
			s.st == ST_CBR_RAS || s.st == ST_HID_DN) begin
			since_ref <= 10'h000;
		end else if (since_ref != 10'h3FF) begin
			since_ref <= since_ref + 10'h001;
		end
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	sequence cas_lead;
		!o_CAS_N && o_RAS_N;
	endsequence
	sequence both_low;
		!o_CAS_N && !o_RAS_N;
	endsequence

	pwr_strobes_a: assert property (s.st == ST_PWR |-> o_RAS_N && o_CAS_N)
		else $error("strobe low during power-up pause");
	ras_only_a: assert property (s.st == ST_ROW && s.kind == KIND_REF_RO |-> o_CAS_N && !o_ADDR[9])
		else $error("row-only refresh with column strobe low or top bit set");
	ref_walk_a: assert property (s.st == ST_ROW && s.kind == KIND_REF_RO && done
		|=> s.ref_row == $past(s.ref_row) + 9'h001)
		else $error("refresh row did not advance");
	cbr_setup_a: assert property ($fell(o_RAS_N) && !o_CAS_N |-> $past(!o_CAS_N, 2))
		else $error("column strobe not set up before row strobe");
	hidden_hold_a: assert property ($rose(s.st == ST_HID_UP) |-> (!o_CAS_N)[*4])
		else $error("column strobe rose during hidden refresh");
	test_seq_a: assert property ($rose(s.st == ST_TEST_UP) |-> $past(both_low) ##0 (o_CAS_N && !o_RAS_N)[*2]
		##1 both_low)
		else $error("counter test strobe order wrong");
	test_start_a: assert property ($rose(s.st == ST_CBR) |-> cas_lead[*2] ##1 both_low)
		else $error("internal refresh did not start column first");
	page_open_a: assert property (s.st == ST_PAGE |-> !o_RAS_N && o_CAS_N)
		else $error("row closed while page open");
	init_count_a: assert property ($fell(s.init_busy) |-> init_ras == 4'(`INIT_CYCLES))
		else $error("initialisation ended without eight row cycles");
	ref_gap_a: assert property (since_ref <= 10'(`REF_CYC + 32))
		else $error("refresh overdue");
	idle_reinit_a: assert property (s.st == ST_IDLE && s.init_left == 4'h0 &&
		s.idle_tmr >= `IDLE_W'(IDLE_LIMIT - 1) |=> s.init_left == 4'(`INIT_CYCLES))
		else $error("no re-initialisation after long idle");

endmodule

// File: dv/dram_model.sv
// behavioural 1M x 1 dynamic memory answering the controller's strobes
// assumes strobes come from registered outputs, so edges are at least a clock apart
`timescale 1ns/1ps

module dram_model (
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic [9:0] i_addr,
	input wire logic i_din,
	output logic o_dout
);
	// ************************************************
	// storage, refresh counter and statistics
	// ************************************************
	logic mem [int];
	logic [8:0] ref_cnt = 9'h000;
	logic [8:0] cbr_row = 9'h000;
	logic [9:0] row = 10'h000;
	logic [9:0] last_row = 10'h000;
	logic open = 1'b0;
	logic cas_seen = 1'b0;
	logic test_armed = 1'b0;
	logic test_on = 1'b0;
	int ro_count = 0;
	int cbr_count = 0;
	int opens = 0;
	int cas_falls = 0;
	int seq_bad = 0;
	int last_ro = -1;
	time first_fall = 0;

	initial o_dout = 1'b0;

	// row strobe fall: latch a row, or internal refresh when column strobe is already low
	always @(negedge i_ras_n) begin
		#1;
		if (first_fall == 0)
			first_fall = $time;
		if (i_cas_n) begin
			row = i_addr; // row opened is refreshed
			open = 1'b1;
			cas_seen = 1'b0;
			opens++;
		end else begin
			cbr_row = ref_cnt; // counter picks the row
			ref_cnt = ref_cnt + 9'h001;
			cbr_count++;
			test_armed = 1'b1;
		end
	end

	// row strobe rise: a cycle that saw no column strobe was a row-only refresh
	always @(posedge i_ras_n) begin
		if (open && !cas_seen) begin
			if (last_ro >= 0 && int'(row[8:0]) != ((last_ro + 1) % 512)) // top bit ignored
				seq_bad++;
			last_ro = int'(row[8:0]);
			ro_count++;
		end
		open = 1'b0;
		test_armed = 1'b0;
		test_on = 1'b0;
	end

	// column strobe rise: output floats, and a raise under low row strobe arms counter test
	always @(posedge i_cas_n) begin
		o_dout = ~o_dout; // released line never keeps its last value
		if (test_armed && !i_ras_n)
			test_on = 1'b1;
	end

	// column strobe fall under low row strobe: one access in the open or test row
	always @(negedge i_cas_n) begin
		#1;
		cas_falls++;
		if (!i_ras_n) begin
			cas_seen = 1'b1;
			last_row = test_on ? {1'b1, cbr_row} : row;
			if (!i_we_n)
				mem[int'({last_row, i_addr})] = i_din;
			else
				o_dout = mem[int'({last_row, i_addr})]; // held while strobe low
		end
	end
endmodule

// File: dv/dram_refresh_and_page_mode_tb_top.sv
// self-checking bench for the dynamic memory controller
// assumes dram_model as the memory and a shortened idle limit
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin total_checks++; if ((ac) !== (ex)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, ac); end end

module dram_refresh_and_page_mode_tb_top;
	import dram_ctrl_pkg::*;
	// ************************************************
	// clock, reset, design and memory
	// ************************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic valid = 1'b0;
	req_t req = '0;
	logic ro_ref = 1'b0;
	logic ready, rd_valid, rd_data, busy, ras_n, cas_n, we_n, din, dout;
	logic [9:0] addr;
	int num_errors = 0;
	int total_checks = 0;
	time rel_t = 0;

	always #25 clk = ~clk;

	dram_ctrl #(.IDLE_LIMIT(400)) uut (.I_CLK(clk), .I_SYS_RST(rst), .i_REQ_VALID(valid), .i_REQ(req),
		.i_RAS_ONLY_REF(ro_ref), .i_DOUT(dout), .o_REQ_READY(ready), .o_RD_VALID(rd_valid),
		.o_RD_DATA(rd_data), .o_INIT_BUSY(busy), .o_RAS_N(ras_n), .o_CAS_N(cas_n), .o_WE_N(we_n),
		.o_ADDR(addr), .o_DIN(din));

	dram_model model (.i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_addr(addr), .i_din(din),
		.o_dout(dout));

	// ************************************************
	// shared tasks
	// ************************************************
	task automatic complete_run();
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one request: offer until taken, then wait for read data
	task automatic do_req(input logic [2:0] thk, input logic wr, input logic [19:0] a, input logic w,
		output logic d);
		int n;
		d = 1'b0;
		@(posedge clk);
		req <= {thk, wr, a, w};
		valid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ready !== 1'b1 && n < 8000);
		valid <= 1'b0;
		n = 0;
		while (!wr && rd_valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		d = rd_data;
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_init();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 6000) begin
			@(posedge clk);
			n++;
		end
		`CHK("init_cycles", 8, model.ro_count)
		`CHK("pause_ok", 1'b1, (model.first_fall - rel_t) >= 200000)
		`CHK("cas_quiet", 0, model.cas_falls)
	endtask

	task automatic t_rw();
		logic d;
		do_req(3'h0, 1'b1, 20'h12345, 1'b1, d);
		do_req(3'h0, 1'b1, 20'h12346, 1'b0, d);
		do_req(3'h0, 1'b0, 20'h12345, 1'b0, d);
		`CHK("rd_a", 1'b1, d)
		do_req(3'h0, 1'b0, 20'h12346, 1'b0, d);
		`CHK("rd_b", 1'b0, d)
	endtask

	task automatic t_page();
		logic d;
		int o0;
		o0 = model.opens;
		do_req(3'h1, 1'b1, 20'h0A801, 1'b1, d);
		do_req(3'h1, 1'b1, 20'h0A802, 1'b0, d);
		do_req(3'h1, 1'b0, 20'h0A801, 1'b0, d);
		`CHK("pg_rd1", 1'b1, d)
		do_req(3'h0, 1'b0, 20'h0A802, 1'b0, d);
		`CHK("pg_rd2", 1'b0, d)
		`CHK("pg_opens", 1, model.opens - o0)
	endtask

	task automatic t_hidden();
		logic d;
		int c0;
		c0 = model.cbr_count;
		do_req(3'h2, 1'b0, 20'h12345, 1'b0, d);
		`CHK("hid_rd", 1'b1, d)
		// look while the column strobe is still held low, before the cycle closes
		repeat (2) @(posedge clk);
		`CHK("hid_cbr", 1'b1, model.cbr_count > c0)
		`CHK("hid_out", 1'b1, dout)
	endtask

	task automatic t_test();
		logic d;
		do_req(3'h4, 1'b0, 20'h00007, 1'b0, d);
		`CHK("tst_row", {1'b1, 9'(model.cbr_count - 1)}, model.last_row)
	endtask

	task automatic t_refresh();
		int r0, c0;
		r0 = model.ro_count;
		ro_ref <= 1'b1;
		repeat (1400) @(posedge clk);
		`CHK("ro_runs", 1'b1, model.ro_count - r0 >= 4)
		`CHK("ro_seq", 0, model.seq_bad)
		c0 = model.cbr_count;
		ro_ref <= 1'b0;
		repeat (700) @(posedge clk);
		`CHK("cbr_runs", 1'b1, model.cbr_count - c0 >= 2)
		`CHK("cbr_cnt", 9'(model.cbr_count), model.ref_cnt)
	endtask

	// ************************************************
	// main sequence and watchdog
	// ************************************************
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rel_t = $time;
		t_init();
		t_rw();
		t_page();
		t_hidden();
		t_test();
		t_refresh();
		complete_run();
	end

	// watchdog cuts a hang short
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		complete_run();
	end
endmodule
